/* pkg/reclose_pkg.sv */
package reclose_pkg;
	// register word offsets (byte addresses)
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] STATUS_ADDR = 8'h04;
	localparam logic [7:0] FAIL_COUNT_ADDR = 8'h08;
	// control register fields
	localparam int LIMIT_W = 16;
	localparam int LIMIT_LSB = 0;
	localparam int OFF_BIT = 16;
	localparam int PERMIT_FORCE_BIT = 17;
	localparam int SHOT_LSB = 18;
	localparam int SHOT_W = 3;
	// status register fields
	localparam int ST_SEALED_BIT = 0;
	localparam int ST_FAIL_BIT = 1;
	localparam int ST_QUAL_BIT = 2;
	localparam int ST_WINDOW_BIT = 3;
	localparam int ST_ACCUM_LSB = 16;
	// reset values: permit forced true, limit zero, off clear, shots disabled
	localparam logic [LIMIT_W-1:0] LIMIT_RST = 16'h0000;
	localparam logic PERMIT_FORCE_RST = 1'b1;
	localparam logic OFF_RST = 1'b0;
	localparam logic [SHOT_W-1:0] SHOT_RST = 3'h0;
	localparam logic [SHOT_W-1:0] SHOT_MIN = 3'h1;
	localparam logic [SHOT_W-1:0] SHOT_MAX = 3'h4;
	// limit time is held in hundredths of a power-system cycle
	localparam int HUNDREDTHS_PER_CYCLE = 100;
	localparam int INTERVALS_PER_CYCLE = 4;
	localparam int FAIL_COUNT_W = 16;
endpackage

/* core/limit_timer.sv */
`timescale 1ns/1ns
module limit_timer #(
	parameter int WIDTH = 16,
	parameter int STEP = 25
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic tick,
	input wire logic load,
	input wire logic run,
	input wire logic [WIDTH-1:0] limit,
	output logic expired,
	output logic [WIDTH-1:0] accum
);
	localparam logic [WIDTH:0] STEP_W = (WIDTH + 1)'(STEP);
	logic [WIDTH-1:0] accum_q;
	logic [WIDTH-1:0] accum_d;
	logic [WIDTH:0] sum;

	always_comb begin
		sum = {1'b0, accum_q} + STEP_W;
		accum_d = accum_q;
		if (tick) begin
			if (load) begin
				accum_d = '0;
			end else if (run && !expired) begin
				accum_d = sum[WIDTH] ? '1 : sum[WIDTH-1:0];
			end
		end
	end

	// elapsed time after this interval reaches the limit
	assign expired = run && (sum >= {1'b0, limit});
	assign accum = accum_q;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			accum_q <= '0;
		end else begin
			accum_q <= accum_d;
		end
	end
endmodule

/* core/reclose_supervision.sv */
`timescale 1ns/1ns
module reclose_supervision (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic interval_tick,
	input wire logic open_interval_timeout,
	input wire logic reclose_permit_condition,
	input wire logic close_output,
	input wire logic lockout_state_flag,
	input wire logic breaker_closed_status,
	input wire logic reclose_initiate,
	input wire logic open_interval_stall,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic qualified_timeout,
	output logic supervision_failure_pulse,
	output logic lockout_request,
	output logic open_interval_advance
);
	import reclose_pkg::*;

	localparam int STEP = HUNDREDTHS_PER_CYCLE / INTERVALS_PER_CYCLE;

	// configuration registers
	logic [LIMIT_W-1:0] limit_q;
	logic [LIMIT_W-1:0] limit_d;
	logic off_q;
	logic off_d;
	logic permit_force_q;
	logic permit_force_d;
	logic [SHOT_W-1:0] shot_q;
	logic [SHOT_W-1:0] shot_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [FAIL_COUNT_W-1:0] fail_count_q;
	logic [FAIL_COUNT_W-1:0] fail_count_d;

	// supervision state
	logic seal_q;
	logic seal_d;
	logic fail_q;
	logic fail_d;
	logic qual_q;
	logic qual_d;
	logic ri_prev_q;
	logic ri_prev_d;

	logic permit;
	logic single_mode;
	logic ri_rise;
	logic seal_ok;
	logic seal_clear;
	logic seal_set;
	logic timer_load;
	logic timer_run;
	logic timer_expired;
	logic [LIMIT_W-1:0] timer_accum;
	logic shots_enabled;

	// forced-true permit keeps the default path free of supervision
	assign permit = permit_force_q | reclose_permit_condition;
	assign single_mode = (limit_q == LIMIT_RST) && !off_q;
	assign ri_rise = reclose_initiate && !ri_prev_q;

	// conditions under which a time-out may seal in
	assign seal_ok = !close_output && !lockout_state_flag && !breaker_closed_status
		&& !ri_rise && !fail_q;

	assign seal_clear = close_output || lockout_state_flag || breaker_closed_status
		|| ri_rise || permit || fail_q;

	assign seal_set = !single_mode && open_interval_timeout && seal_ok;

	assign timer_load = seal_set && !seal_q;
	assign timer_run = seal_q && !off_q;
	assign shots_enabled = (shot_q >= SHOT_MIN) && (shot_q <= SHOT_MAX);

	limit_timer #(
		.WIDTH(LIMIT_W),
		.STEP(STEP)
	) u_limit_timer (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.tick(interval_tick),
		.load(timer_load),
		.run(timer_run),
		.limit(limit_q),
		.expired(timer_expired),
		.accum(timer_accum)
	);

	// evaluation once per processing interval
	always_comb begin
		seal_d = seal_q;
		fail_d = fail_q;
		qual_d = qual_q;
		ri_prev_d = ri_prev_q;
		if (interval_tick) begin
			ri_prev_d = reclose_initiate;
			qual_d = 1'b0;
			fail_d = 1'b0;
			if (single_mode) begin
				seal_d = 1'b0;
				if (open_interval_timeout) begin
					qual_d = permit;
					fail_d = !permit;
				end
			end else begin
				if (seal_q) begin
					if (permit && !seal_clear_other()) begin
						qual_d = 1'b1;
					end else if (!permit && timer_expired && !seal_clear_other()) begin
						fail_d = 1'b1;
					end
				end else if (seal_set && permit) begin
					qual_d = 1'b1;
				end
				if (seal_set && !permit) begin
					seal_d = 1'b1;
				end else if (seal_clear) begin
					seal_d = 1'b0;
				end else if (fail_d) begin
					seal_d = 1'b0;
				end
			end
		end
	end

	// clear terms other than the permit itself
	function automatic logic seal_clear_other();
		seal_clear_other = close_output || lockout_state_flag || breaker_closed_status
			|| ri_rise || fail_q;
	endfunction

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			seal_q <= 1'b0;
			fail_q <= 1'b0;
			qual_q <= 1'b0;
			ri_prev_q <= 1'b0;
		end else begin
			seal_q <= seal_d;
			fail_q <= fail_d;
			qual_q <= qual_d;
			ri_prev_q <= ri_prev_d;
		end
	end

	assign qualified_timeout = qual_q;
	assign supervision_failure_pulse = fail_q;
	assign lockout_request = fail_q && shots_enabled;
	assign open_interval_advance = !open_interval_stall;

	// register bus
	always_comb begin
		limit_d = limit_q;
		off_d = off_q;
		permit_force_d = permit_force_q;
		shot_d = shot_q;
		fail_count_d = fail_count_q;
		rdata_d = '0;
		if (interval_tick && fail_d && !fail_q) begin
			fail_count_d = fail_count_q + 1'b1;
		end
		if (reg_wr) begin
			case (reg_addr)
				CTRL_ADDR: begin
					limit_d = reg_wdata[LIMIT_LSB +: LIMIT_W];
					off_d = reg_wdata[OFF_BIT];
					permit_force_d = reg_wdata[PERMIT_FORCE_BIT];
					shot_d = reg_wdata[SHOT_LSB +: SHOT_W];
				end
				FAIL_COUNT_ADDR: begin
					fail_count_d = '0;
				end
				default: begin
				end
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				CTRL_ADDR: begin
					rdata_d[LIMIT_LSB +: LIMIT_W] = limit_q;
					rdata_d[OFF_BIT] = off_q;
					rdata_d[PERMIT_FORCE_BIT] = permit_force_q;
					rdata_d[SHOT_LSB +: SHOT_W] = shot_q;
				end
				STATUS_ADDR: begin
					rdata_d[ST_SEALED_BIT] = seal_q;
					rdata_d[ST_FAIL_BIT] = fail_q;
					rdata_d[ST_QUAL_BIT] = qual_q;
					rdata_d[ST_WINDOW_BIT] = !single_mode;
					rdata_d[ST_ACCUM_LSB +: LIMIT_W] = timer_accum;
				end
				FAIL_COUNT_ADDR: begin
					rdata_d[FAIL_COUNT_W-1:0] = fail_count_q;
				end
				default: begin
					rdata_d = '0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			limit_q <= LIMIT_RST;
			off_q <= OFF_RST;
			permit_force_q <= PERMIT_FORCE_RST;
			shot_q <= SHOT_RST;
			fail_count_q <= '0;
			rdata_q <= '0;
		end else begin
			limit_q <= limit_d;
			off_q <= off_d;
			permit_force_q <= permit_force_d;
			shot_q <= shot_d;
			fail_count_q <= fail_count_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

	// checks
	AST_SINGLE_PASS: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		interval_tick && single_mode && open_interval_timeout && permit
		|=> qualified_timeout && !supervision_failure_pulse)
		else $error("single check with permit did not forward time-out");

	AST_SINGLE_FAIL: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		interval_tick && single_mode && open_interval_timeout && !permit
		|=> supervision_failure_pulse && !qualified_timeout)
		else $error("single check without permit did not fail");

	AST_FAIL_ONE_INTERVAL: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		supervision_failure_pulse && interval_tick |=> !supervision_failure_pulse)
		else $error("failure pulse lasted more than one interval");

	AST_LOCKOUT_SHOTS: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		$rose(supervision_failure_pulse) && shot_q >= SHOT_MIN && shot_q <= SHOT_MAX
		|-> lockout_request)
		else $error("failure did not request lockout");

	AST_NO_LOCKOUT_DISABLED: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		shot_q == SHOT_RST |-> !lockout_request)
		else $error("lockout requested with reclosing disabled");

	AST_SEAL_BREAKER: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		interval_tick && breaker_closed_status |=> !seal_q)
		else $error("seal held with breaker closed");

	AST_SEAL_RISE: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		interval_tick && reclose_initiate && !ri_prev_q |=> !seal_q)
		else $error("seal held across initiate edge");

	AST_SEAL_PERMIT: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		interval_tick && seal_q && permit && !seal_clear_other()
		|=> qualified_timeout && !seal_q)
		else $error("sealed time-out not forwarded on permit");

	AST_OFF_NO_FAIL: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		interval_tick && off_q && !open_interval_timeout |=> !supervision_failure_pulse)
		else $error("failure while limit timer off");

	AST_STALL: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		open_interval_stall |-> !open_interval_advance)
		else $error("open interval advanced while stalled");

	AST_CLOSE_NO_SEAL: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		interval_tick && close_output |=> !seal_q)
		else $error("time-out sealed while close output high");

	AST_LOCKOUT_NO_SEAL: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		interval_tick && lockout_state_flag |=> !seal_q)
		else $error("time-out sealed during lockout");

	AST_WINDOW_SEAL: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		interval_tick && seal_set && !permit |=> seal_q)
		else $error("window mode time-out did not seal");

	AST_WINDOW_PASS: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		interval_tick && seal_set && permit |=> qualified_timeout && !seal_q)
		else $error("window time-out with permit not forwarded");

	AST_WINDOW_EXPIRY: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		interval_tick && seal_q && !single_mode && !permit && timer_expired
		&& !seal_clear_other() |=> supervision_failure_pulse && !qualified_timeout)
		else $error("window expiry did not fail");

	AST_NO_EARLY_FAIL: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		interval_tick && !single_mode && !timer_expired |=> !supervision_failure_pulse)
		else $error("window failure before the limit was reached");

	AST_SEAL_CLEAR: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		interval_tick && seal_clear |=> !seal_q)
		else $error("seal held after a clearing condition");

	AST_OFF_HOLD: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		interval_tick && off_q && seal_q && !seal_clear |=> seal_q)
		else $error("seal dropped while limit timer off");

	AST_TICK_ONLY: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		!interval_tick |=> $stable(qualified_timeout) && $stable(supervision_failure_pulse))
		else $error("supervision outputs changed without a tick");
endmodule

/* verif/reclose_partner.sv */
`timescale 1ns/1ns
module reclose_partner (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic fire,
	input wire logic lockout_request,
	output logic interval_tick,
	output logic open_interval_timeout,
	output logic lockout_state_flag
);
	logic [1:0] cnt_q;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= 2'h0;
			interval_tick <= 1'b0;
			open_interval_timeout <= 1'b0;
			lockout_state_flag <= 1'b0;
		end else begin
			cnt_q <= cnt_q + 2'h1;
			interval_tick <= (cnt_q == 2'h2);
			// time-out stands until a tick has taken it
			if (fire)
				open_interval_timeout <= 1'b1;
			else if (interval_tick)
				open_interval_timeout <= 1'b0;
			// new open interval leaves lockout, a lockout request enters it
			if (fire)
				lockout_state_flag <= 1'b0;
			else if (lockout_request)
				lockout_state_flag <= 1'b1;
		end
	end
endmodule

/* verif/test_reclose_supervision.sv */
`timescale 1ns/1ns
module test_reclose_supervision;
	import reclose_pkg::*;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic fire = 1'b0, permit = 1'b0, brk = 1'b0, init = 1'b0, stall = 1'b0, close_out = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic reg_wr = 1'b0, reg_rd = 1'b0;
	logic tick, timeout, lo_flag, qual, fail, lo_req, adv;
	int errors = 0, compares = 0;
	always #2 core_clk = ~core_clk;
	reclose_partner reclose_partner_i (.core_clk(core_clk), .reset_n(reset_n), .fire(fire),
		.lockout_request(lo_req), .interval_tick(tick), .open_interval_timeout(timeout),
		.lockout_state_flag(lo_flag));
	reclose_supervision reclose_supervision_i (.core_clk(core_clk), .reset_n(reset_n),
		.interval_tick(tick), .open_interval_timeout(timeout),
		.reclose_permit_condition(permit), .close_output(close_out),
		.lockout_state_flag(lo_flag), .breaker_closed_status(brk), .reclose_initiate(init),
		.open_interval_stall(stall), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .qualified_timeout(qual),
		.supervision_failure_pulse(fail), .lockout_request(lo_req),
		.open_interval_advance(adv));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata & m, e);
	endtask
	task automatic sync();
		@(posedge core_clk iff tick);
		#1;
	endtask
	// one processing interval: drive, then check outputs after the next tick
	task automatic iv(input logic p, input logic f, input logic b, input logic i,
		input logic eq, input logic ef, input logic el);
		@(posedge core_clk);
		permit <= p;
		fire <= f;
		brk <= b;
		init <= i;
		@(posedge core_clk);
		fire <= 1'b0;
		@(posedge core_clk iff tick);
		#1 chk({29'h0, qual, fail, lo_req}, {29'h0, eq, ef, el});
	endtask
	task automatic close_drive(input logic c);
		@(posedge core_clk);
		close_out <= c;
	endtask
	task automatic done(input string name);
		$display("test %s finished", name);
	endtask
	task automatic end_sim();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#100000;
		errors++;
		end_sim();
	end
	initial begin
		repeat (10) @(posedge core_clk);
		reset_n <= 1'b1;
		rd(CTRL_ADDR, 32'hFFFFFFFF, 32'h00020000);
		rd(8'h0C, 32'hFFFFFFFF, 32'h00000000);
		sync();
		iv(0, 1, 0, 0, 1, 0, 0);
		iv(0, 0, 0, 0, 0, 0, 0);
		done("defaults");
		wr(FAIL_COUNT_ADDR, 32'h0);
		for (int s = 0; s < 6; s++) begin
			wr(CTRL_ADDR, 32'(s) << SHOT_LSB);
			sync();
			iv(0, 1, 0, 0, 0, 1, s >= 1 && s <= 4);
			iv(0, 0, 0, 0, 0, 0, 0);
			iv(1, 1, 0, 0, 1, 0, 0);
		end
		rd(FAIL_COUNT_ADDR, 32'hFFFFFFFF, 32'h00000006);
		done("single check");
		// shots 1, limit 50 hundredths
		wr(CTRL_ADDR, 32'h00040032);
		sync();
		iv(0, 1, 0, 0, 0, 0, 0);
		iv(0, 0, 0, 0, 0, 0, 0);
		iv(0, 0, 0, 0, 0, 1, 1);
		iv(0, 0, 0, 0, 0, 0, 0);
		iv(0, 1, 0, 0, 0, 0, 0);
		iv(1, 0, 0, 0, 1, 0, 0);
		iv(0, 0, 0, 0, 0, 0, 0);
		iv(0, 0, 0, 0, 0, 0, 0);
		iv(1, 1, 0, 0, 1, 0, 0);
		iv(0, 1, 1, 0, 0, 0, 0);
		iv(0, 0, 0, 0, 0, 0, 0);
		iv(0, 0, 0, 0, 0, 0, 0);
		iv(0, 1, 0, 1, 0, 0, 0);
		iv(0, 0, 0, 1, 0, 0, 0);
		iv(0, 0, 0, 0, 0, 0, 0);
		iv(0, 1, 0, 0, 0, 0, 0);
		iv(0, 0, 1, 0, 0, 0, 0);
		iv(0, 0, 0, 0, 0, 0, 0);
		iv(1, 0, 0, 0, 0, 0, 0);
		close_drive(1'b1);
		iv(0, 1, 0, 0, 0, 0, 0);
		close_drive(1'b0);
		iv(0, 0, 0, 0, 0, 0, 0);
		iv(0, 0, 0, 0, 0, 0, 0);
		iv(0, 1, 0, 0, 0, 0, 0);
		close_drive(1'b1);
		iv(0, 0, 0, 0, 0, 0, 0);
		close_drive(1'b0);
		iv(0, 0, 0, 0, 0, 0, 0);
		iv(1, 0, 0, 0, 0, 0, 0);
		done("window");
		// limit timer off
		wr(CTRL_ADDR, 32'h00050032);
		sync();
		iv(0, 1, 0, 0, 0, 0, 0);
		repeat (4) iv(0, 0, 0, 0, 0, 0, 0);
		rd(STATUS_ADDR, 32'h00000001, 32'h00000001);
		sync();
		iv(1, 0, 0, 0, 1, 0, 0);
		done("timer off");
		for (int v = 0; v < 2; v++) begin
			@(posedge core_clk);
			stall <= v[0];
			#1 chk({31'h0, adv}, {31'h0, !v[0]});
		end
		done("stall");
		end_sim();
	end
endmodule
